// ==== rtl/csil_params.svh ====
// Register map, field positions, reset values and timing for the lamp block
`ifndef CSIL_PARAMS_SVH
`define CSIL_PARAMS_SVH

`define CSIL_CTRL_OFS 8'h00
`define CSIL_THR_ELOW_OFS 8'h04
`define CSIL_THR_LOW_OFS 8'h08
`define CSIL_THR_HIGH_OFS 8'h0C
`define CSIL_THR_EHIGH_OFS 8'h10
`define CSIL_STATUS_OFS 8'h14
`define CSIL_IRQ_STAT_OFS 8'h18
`define CSIL_IRQ_MASK_OFS 8'h1C

`define CSIL_CTRL_HOLD_BIT 0
`define CSIL_CTRL_RST 32'h00000000
`define CSIL_THR_ELOW_RST 32'h00000200
`define CSIL_THR_LOW_RST 32'h00000300
`define CSIL_THR_HIGH_RST 32'h00000C00
`define CSIL_THR_EHIGH_RST 32'h00000D00

`define CSIL_IRQ_W 6
`define CSIL_EV_NEW_ALARM 0
`define CSIL_EV_CUT_ON 1
`define CSIL_EV_CUT_OFF 2
`define CSIL_EV_SUP_A 3
`define CSIL_EV_SUP_B 4
`define CSIL_EV_SYNC_LOST 5

`define CSIL_CLK_PERIOD_NS 25
`define CSIL_BLINK_HALF_NS 250000000

`endif

// ==== rtl/csil_pkg.sv ====
// Types shared by the lamp block modules
package csil_pkg;
  typedef enum logic [1:0] {
    CSIL_OFF,
    CSIL_GREEN,
    CSIL_AMBER,
    CSIL_RED
  } csil_colour_t;

  typedef enum logic {
    CSIL_CUT_IDLE,
    CSIL_CUT_ACTIVE
  } csil_cut_state_t;
endpackage

// ==== rtl/csil_supply_class.sv ====
// Classifies one supply level into a green, amber or red lamp colour
`timescale 1ns/100ps
module csil_supply_class
  import csil_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  csil_supply_if.cls sup
);
  csil_colour_t colour_q;
  csil_colour_t colour_d;

  always_comb
  begin
    // Red beyond either extreme
    if (sup.level > sup.ehigh || sup.level < sup.elow)
      colour_d = CSIL_RED;
    // Amber in either outer band
    else if (sup.level > sup.high || sup.level < sup.low)
      colour_d = CSIL_AMBER;
    // Green inside the normal band, edges included
    else
      colour_d = CSIL_GREEN;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      colour_q <= CSIL_OFF;
    else
      colour_q <= colour_d;
  end

  assign sup.colour = colour_q;
endmodule

// ==== rtl/csil_supply_if.sv ====
// Supply level, its four thresholds and the resulting lamp colour
`timescale 1ns/100ps
interface csil_supply_if
  import csil_pkg::*;
#(
  parameter int W = 12
);
  logic [W-1:0] level;
  logic [W-1:0] elow;
  logic [W-1:0] low;
  logic [W-1:0] high;
  logic [W-1:0] ehigh;
  csil_colour_t colour;

  modport cls (input level, input elow, input low, input high, input ehigh,
    output colour);
  modport top (output level, output elow, output low, output high,
    output ehigh, input colour);
endinterface

// ==== rtl/csil_top.sv ====
// Front-panel lamp controller with APB registers and interrupt
//
// Notes on behaviour
// - Fault lamp stays steadily lit while the card is held in reset.
// - Fault lamp flashes while booting or writing a database.
// - Role lamp green when active, amber when standby.
// - Card lamps blink while the active card writes either database.
// - Severe lamp red while any critical local alarm exists.
// - Serious lamp red while any major local alarm exists.
// - Low-tier lamp amber while any minor local alarm exists.
// - Far-node lamp red while any remote terminal reports an alarm.
// - Timing lamp green only while locked to an external reference.
// - Cutoff button lights cutoff lamp and opens audible closure; here a press does so only while some alarm is present.
// - A new alarm during cutoff ends the cutoff.
// - Cutoff lamp and audible control reset once originating alarm clears.
// - Supply A lamp green between low and high thresholds.
// - Supply A lamp amber in either outer threshold band.
// - Supply A lamp red beyond either extreme threshold.
// - Supply B lamp classified the same way from supply B.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "csil_params.svh"
module csil_top
  import csil_pkg::*;
#(
  parameter int SUPPLY_W = 12,
  parameter int unsigned BLINK_HALF_CYCLES =
    `CSIL_BLINK_HALF_NS / `CSIL_CLK_PERIOD_NS
)
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic booting_in,
  input wire logic db_write_in,
  input wire logic peer_db_write_in,
  input wire logic active_role_in,
  input wire logic severe_alarm_in,
  input wire logic serious_alarm_in,
  input wire logic minor_alarm_in,
  input wire logic far_node_alarm_in,
  input wire logic timing_locked_in,
  input wire logic alarm_cutoff_button_in,
  input wire logic [SUPPLY_W-1:0] supply_a_level_in,
  input wire logic [SUPPLY_W-1:0] supply_b_level_in,
  output logic fault_led_out,
  output logic [1:0] role_led_out,
  output logic severe_alarm_led_out,
  output logic serious_alarm_led_out,
  output logic minor_alarm_led_out,
  output logic far_node_alarm_led_out,
  output logic timing_led_out,
  output logic alarm_cutoff_led_out,
  output logic audible_alarm_out,
  output logic [1:0] supply_a_led_out,
  output logic [1:0] supply_b_led_out,
  output logic irq_out
);
  localparam int unsigned BLINK_LAST =
    (BLINK_HALF_CYCLES > 1) ? BLINK_HALF_CYCLES - 1 : 0;

  // Lamp drive as {red, green}; amber lights both dies
  function automatic logic [1:0] colour_bits(input csil_colour_t c);
    logic [1:0] b;
    b = 2'h0;
    unique case (c)
      CSIL_OFF: b = 2'h0;
      CSIL_GREEN: b = 2'h1;
      CSIL_AMBER: b = 2'h3;
      CSIL_RED: b = 2'h2;
    endcase
    return b;
  endfunction

  logic [31:0] ctrl_q;
  logic [SUPPLY_W-1:0] thr_elow_q;
  logic [SUPPLY_W-1:0] thr_low_q;
  logic [SUPPLY_W-1:0] thr_high_q;
  logic [SUPPLY_W-1:0] thr_ehigh_q;
  logic [`CSIL_IRQ_W-1:0] irq_stat_q;
  logic [`CSIL_IRQ_W-1:0] irq_mask_q;
  logic [`CSIL_IRQ_W-1:0] irq_ev;
  logic [31:0] blink_cnt_q;
  logic blink_phase_q;
  logic [3:0] alarm_vec;
  logic [3:0] alarm_prev_q;
  logic [3:0] alarm_snap_q;
  logic button_prev_q;
  logic timing_prev_q;
  logic press;
  logic new_alarm;
  logic snap_clear;
  logic writing;
  logic hold;
  csil_cut_state_t cut_state_q;
  csil_colour_t role_d;
  csil_colour_t sup_colour [2];
  csil_colour_t sup_prev_q [2];
  logic [SUPPLY_W-1:0] sup_level [2];
  logic apb_wr;
  logic apb_setup;
  logic addr_hit;
  logic [31:0] rdata_d;

  assign hold = ctrl_q[`CSIL_CTRL_HOLD_BIT];
  assign writing = db_write_in | peer_db_write_in;
  assign alarm_vec = {far_node_alarm_in, minor_alarm_in, serious_alarm_in,
    severe_alarm_in};
  assign press = alarm_cutoff_button_in & ~button_prev_q;
  assign new_alarm = |(alarm_vec & ~alarm_prev_q);
  assign snap_clear = ~|(alarm_vec & alarm_snap_q);

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      blink_cnt_q <= 32'h00000000;
      blink_phase_q <= 1'b0;
    end
    else if (blink_cnt_q >= BLINK_LAST)
    begin
      blink_cnt_q <= 32'h00000000;
      blink_phase_q <= ~blink_phase_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 32'h00000001;
  end

  // Edge history for button, alarms and timing lock
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      button_prev_q <= 1'b0;
      alarm_prev_q <= 4'h0;
      timing_prev_q <= 1'b0;
    end
    else
    begin
      button_prev_q <= alarm_cutoff_button_in;
      alarm_prev_q <= alarm_vec;
      timing_prev_q <= timing_locked_in;
    end
  end

  // Cutoff only engages with something to silence; snapshot remembers it
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cut_state_q <= CSIL_CUT_IDLE;
      alarm_snap_q <= 4'h0;
    end
    else
    begin
      unique case (cut_state_q)
        CSIL_CUT_IDLE:
        begin
          if (press && |alarm_vec)
          begin
            cut_state_q <= CSIL_CUT_ACTIVE;
            alarm_snap_q <= alarm_vec;
          end
        end
        CSIL_CUT_ACTIVE:
        begin
          if (new_alarm)
            cut_state_q <= CSIL_CUT_IDLE;
          else if (snap_clear)
            cut_state_q <= CSIL_CUT_IDLE;
        end
      endcase
    end
  end

  // lamp and closure follow the cutoff state
  assign alarm_cutoff_led_out = (cut_state_q == CSIL_CUT_ACTIVE);
  assign audible_alarm_out = |alarm_prev_q &&
    (cut_state_q == CSIL_CUT_IDLE);

  always_comb
  begin
    role_d = active_role_in ? CSIL_GREEN : CSIL_AMBER;
    if (active_role_in && writing && !blink_phase_q)
      role_d = CSIL_OFF;
  end

  // Card and network lamps
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fault_led_out <= 1'b1;
      role_led_out <= 2'h0;
      severe_alarm_led_out <= 1'b0;
      serious_alarm_led_out <= 1'b0;
      minor_alarm_led_out <= 1'b0;
      far_node_alarm_led_out <= 1'b0;
      timing_led_out <= 1'b0;
    end
    else
    begin
      if (hold)
        fault_led_out <= 1'b1;
      else if (booting_in || writing)
        fault_led_out <= blink_phase_q;
      else
        fault_led_out <= 1'b0;
      role_led_out <= colour_bits(role_d);
      severe_alarm_led_out <= severe_alarm_in;
      serious_alarm_led_out <= serious_alarm_in;
      minor_alarm_led_out <= minor_alarm_in;
      far_node_alarm_led_out <= far_node_alarm_in;
      timing_led_out <= timing_locked_in;
    end
  end

  assign sup_level[0] = supply_a_level_in;
  assign sup_level[1] = supply_b_level_in;

  for (genvar g = 0; g < 2; g++)
  begin : g_sup
    csil_supply_if #(.W(SUPPLY_W)) sif ();
    assign sif.level = sup_level[g];
    assign sif.elow = thr_elow_q;
    assign sif.low = thr_low_q;
    assign sif.high = thr_high_q;
    assign sif.ehigh = thr_ehigh_q;
    assign sup_colour[g] = sif.colour;
    csil_supply_class u_class (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .sup(sif.cls)
    );
  end

  assign supply_a_led_out = colour_bits(sup_colour[0]);
  assign supply_b_led_out = colour_bits(sup_colour[1]);

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sup_prev_q[0] <= CSIL_OFF;
      sup_prev_q[1] <= CSIL_OFF;
    end
    else
    begin
      sup_prev_q[0] <= sup_colour[0];
      sup_prev_q[1] <= sup_colour[1];
    end
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[`CSIL_EV_NEW_ALARM] = new_alarm;
    irq_ev[`CSIL_EV_CUT_ON] = (cut_state_q == CSIL_CUT_IDLE) && press &&
      |alarm_vec;
    irq_ev[`CSIL_EV_CUT_OFF] = (cut_state_q == CSIL_CUT_ACTIVE) &&
      (new_alarm || snap_clear);
    irq_ev[`CSIL_EV_SUP_A] = sup_colour[0] != sup_prev_q[0];
    irq_ev[`CSIL_EV_SUP_B] = sup_colour[1] != sup_prev_q[1];
    irq_ev[`CSIL_EV_SYNC_LOST] = timing_prev_q & ~timing_locked_in;
  end

  // APB: zero wait states, error on unmapped offsets
  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign apb_setup = psel_in & ~penable_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_hit;

  always_comb
  begin
    addr_hit = 1'b1;
    rdata_d = 32'h00000000;
    unique case (paddr_in)
      `CSIL_CTRL_OFS: rdata_d = ctrl_q;
      `CSIL_THR_ELOW_OFS: rdata_d[SUPPLY_W-1:0] = thr_elow_q;
      `CSIL_THR_LOW_OFS: rdata_d[SUPPLY_W-1:0] = thr_low_q;
      `CSIL_THR_HIGH_OFS: rdata_d[SUPPLY_W-1:0] = thr_high_q;
      `CSIL_THR_EHIGH_OFS: rdata_d[SUPPLY_W-1:0] = thr_ehigh_q;
      `CSIL_STATUS_OFS: rdata_d[9:0] = {alarm_snap_q, blink_phase_q,
        alarm_cutoff_led_out, sup_colour[1], sup_colour[0]};
      `CSIL_IRQ_STAT_OFS: rdata_d[`CSIL_IRQ_W-1:0] = irq_stat_q;
      `CSIL_IRQ_MASK_OFS: rdata_d[`CSIL_IRQ_W-1:0] = irq_mask_q;
      default: addr_hit = 1'b0;
    endcase
  end

  // Read data captured in setup so it is stable for the access phase
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      prdata_out <= 32'h00000000;
    else if (apb_setup && !pwrite_in)
      prdata_out <= rdata_d;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_q <= `CSIL_CTRL_RST;
      thr_elow_q <= SUPPLY_W'(`CSIL_THR_ELOW_RST);
      thr_low_q <= SUPPLY_W'(`CSIL_THR_LOW_RST);
      thr_high_q <= SUPPLY_W'(`CSIL_THR_HIGH_RST);
      thr_ehigh_q <= SUPPLY_W'(`CSIL_THR_EHIGH_RST);
      irq_mask_q <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr_in == `CSIL_CTRL_OFS)
        ctrl_q <= {31'h00000000, pwdata_in[`CSIL_CTRL_HOLD_BIT]};
      if (paddr_in == `CSIL_THR_ELOW_OFS)
        thr_elow_q <= pwdata_in[SUPPLY_W-1:0];
      if (paddr_in == `CSIL_THR_LOW_OFS)
        thr_low_q <= pwdata_in[SUPPLY_W-1:0];
      if (paddr_in == `CSIL_THR_HIGH_OFS)
        thr_high_q <= pwdata_in[SUPPLY_W-1:0];
      if (paddr_in == `CSIL_THR_EHIGH_OFS)
        thr_ehigh_q <= pwdata_in[SUPPLY_W-1:0];
      if (paddr_in == `CSIL_IRQ_MASK_OFS)
        irq_mask_q <= pwdata_in[`CSIL_IRQ_W-1:0];
    end
  end

  // Sticky status; a fresh event beats a simultaneous clear
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      irq_stat_q <= '0;
    else if (apb_wr && paddr_in == `CSIL_IRQ_STAT_OFS)
      irq_stat_q <= (irq_stat_q & ~pwdata_in[`CSIL_IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_press_armed;
    !alarm_cutoff_button_in ##1 alarm_cutoff_button_in && |alarm_vec &&
      cut_state_q == CSIL_CUT_IDLE;
  endsequence

  sequence s_cut_broken;
    cut_state_q == CSIL_CUT_ACTIVE && new_alarm;
  endsequence

  chk_fault_hold: assert property (hold |=> fault_led_out)
    else $error("fault lamp not steady while held");
  chk_fault_flash: assert property (
    (!hold && (booting_in || writing)) |=>
      fault_led_out == $past(blink_phase_q))
    else $error("fault lamp not flashing while busy");
  chk_role_standby: assert property (!active_role_in |=>
    role_led_out == 2'h3)
    else $error("standby role lamp not amber");
  chk_role_blink: assert property (
    active_role_in && writing && !blink_phase_q |=> role_led_out == 2'h0)
    else $error("role lamp not blinking during write");
  chk_alarm_lamps: assert property (1'b1 |=>
    {far_node_alarm_led_out, minor_alarm_led_out, serious_alarm_led_out,
      severe_alarm_led_out} == $past(alarm_vec))
    else $error("alarm lamps do not track alarms");
  chk_sync_lamp: assert property ((!timing_locked_in)[*2] |->
    !timing_led_out)
    else $error("timing lamp lit without lock");
  chk_cutoff_engage: assert property (s_press_armed |=>
    alarm_cutoff_led_out ##0 !audible_alarm_out)
    else $error("cutoff did not engage");
  chk_cutoff_new: assert property (s_cut_broken |=>
    !alarm_cutoff_led_out ##0 audible_alarm_out)
    else $error("new alarm did not end cutoff");
  chk_cutoff_clear: assert property (
    cut_state_q == CSIL_CUT_ACTIVE && snap_clear |=> !alarm_cutoff_led_out)
    else $error("cutoff not reset after alarm cleared");
  chk_supply_green: assert property (
    supply_a_level_in >= thr_low_q && supply_a_level_in <= thr_high_q &&
      $stable(thr_low_q) |=> supply_a_led_out == 2'h1)
    else $error("supply A not green in band");
  chk_supply_amber: assert property (
    supply_a_level_in > thr_high_q && supply_a_level_in <= thr_ehigh_q &&
      $stable(thr_high_q) |=> supply_a_led_out == 2'h3)
    else $error("supply A not amber in upper band");
  chk_supply_red: assert property (
    supply_b_level_in < thr_elow_q && $stable(thr_elow_q) |=>
      supply_b_led_out == 2'h2)
    else $error("supply B not red below extreme");
  chk_irq_sticky: assert property (irq_ev[`CSIL_EV_NEW_ALARM] |=>
    irq_stat_q[`CSIL_EV_NEW_ALARM] [*2])
    else $error("event bit lost");
endmodule

// ==== verif/csil_panel_model.sv ====
// Front panel: cutoff button pressed by a hand, role lamp watched
`timescale 1ns/100ps
module csil_panel_model
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic press_req_in,
  input wire logic [1:0] role_led_in,
  output logic alarm_cutoff_button_out,
  output logic pull_ok_out
);
  logic req_q;
  logic [1:0] hold_q;
  logic [1:0] role_q;
  logic [4:0] quiet_q;

  // A hand holds the button for three cycles, never a one-cycle glitch
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      req_q <= 1'b0;
      hold_q <= 2'h0;
    end
    else
    begin
      req_q <= press_req_in;
      if (press_req_in && !req_q && hold_q == 2'h0)
        hold_q <= 2'h3;
      else if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
    end
  end
  assign alarm_cutoff_button_out = (hold_q != 2'h0);

  // removal only after a quiet role lamp
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      role_q <= 2'h0;
      quiet_q <= 5'h0;
    end
    else
    begin
      role_q <= role_led_in;
      if (role_led_in != role_q)
        quiet_q <= 5'h0;
      else if (quiet_q != 5'h1F)
        quiet_q <= quiet_q + 5'h1;
    end
  end
  assign pull_ok_out = (quiet_q >= 5'h10);
endmodule

// ==== verif/tb_card_status_indicator_logic.sv ====
// Self-checking bench for the front-panel lamp controller
`timescale 1ns/100ps
`include "csil_params.svh"
module tb_card_status_indicator_logic;
  localparam int N = 4;
  logic mclk_in = 0;
  logic nrst_in = 0;
  logic psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0;
  logic booting_in = 0, db_write_in = 0, peer_db_write_in = 0;
  logic active_role_in = 0, timing_locked_in = 0, press_req = 0;
  logic [3:0] alm_in = 0;
  logic [11:0] supply_a_level_in = 12'h800, supply_b_level_in = 12'h800;
  logic [31:0] prdata_out, rd, r;
  logic pready_out, pslverr_out, fault_led_out, timing_led_out, irq_out;
  logic severe_alarm_led_out, serious_alarm_led_out, minor_alarm_led_out;
  logic far_node_alarm_led_out, alarm_cutoff_led_out, audible_alarm_out;
  logic [1:0] role_led_out, supply_a_led_out, supply_b_led_out;
  logic alarm_cutoff_button_in, pull_ok, err;
  logic [3:0] a;
  int n_fail = 0, tests_run = 0, seed = 71302, hold = 0, live = 0;
  int thr[4] = '{`CSIL_THR_ELOW_RST, `CSIL_THR_LOW_RST, `CSIL_THR_HIGH_RST,
    `CSIL_THR_EHIGH_RST};
  int nt[4] = '{32'h100, 32'h400, 32'h800, 32'h900};
  int alm_q, btn_q, e_cut, snap, e_tim, e_role, e_fault, e_sa, e_sb;
  int c0, c1, f1;

  csil_top #(.BLINK_HALF_CYCLES(N)) dut (.mclk_in, .nrst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .booting_in, .db_write_in,
    .peer_db_write_in, .active_role_in, .severe_alarm_in(alm_in[0]),
    .serious_alarm_in(alm_in[1]), .minor_alarm_in(alm_in[2]),
    .far_node_alarm_in(alm_in[3]), .timing_locked_in,
    .alarm_cutoff_button_in, .supply_a_level_in, .supply_b_level_in,
    .fault_led_out, .role_led_out, .severe_alarm_led_out,
    .serious_alarm_led_out, .minor_alarm_led_out, .far_node_alarm_led_out,
    .timing_led_out, .alarm_cutoff_led_out, .audible_alarm_out,
    .supply_a_led_out, .supply_b_led_out, .irq_out);

  csil_panel_model panel (.mclk_in, .nrst_in, .press_req_in(press_req),
    .role_led_in(role_led_out),
    .alarm_cutoff_button_out(alarm_cutoff_button_in),
    .pull_ok_out(pull_ok));

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Lamp code {red,green}; band edges count as the inner band
  function automatic int cls(int v);
    if (v < thr[0] || v > thr[3])
      return 2;
    if (v < thr[1] || v > thr[2])
      return 3;
    return 1;
  endfunction

  always @(posedge mclk_in)
  begin
    a = alm_in;
    if (!nrst_in)
    begin
      alm_q = 0;
      btn_q = 0;
      e_cut = 0;
      snap = 0;
    end
    else
    begin
      if (e_cut != 0 && ((a & ~alm_q) != 0 || (a & snap) == 0))
        e_cut = 0;
      else if (e_cut == 0 && alarm_cutoff_button_in && btn_q == 0 && a != 0)
      begin
        e_cut = 1;
        snap = a;
      end
      alm_q = a;
      btn_q = alarm_cutoff_button_in;
      e_tim = timing_locked_in;
      e_role = (active_role_in && (db_write_in || peer_db_write_in)) ? -1 :
        (active_role_in ? 1 : 3);
      e_fault = hold ? 1 : ((booting_in || db_write_in ||
        peer_db_write_in) ? -1 : 0);
      e_sa = cls(supply_a_level_in);
      e_sb = cls(supply_b_level_in);
    end
  end

  always @(negedge mclk_in)
  begin
    if (live)
    begin
      check({far_node_alarm_led_out, minor_alarm_led_out,
        serious_alarm_led_out, severe_alarm_led_out},
        alm_q);
      check(timing_led_out, e_tim);
      check(alarm_cutoff_led_out, e_cut);
      check(audible_alarm_out, alm_q != 0 && e_cut == 0);
      check(supply_a_led_out, e_sa);
      check(supply_b_led_out, e_sb);
      if (e_role >= 0) check(role_led_out, e_role);
      if (e_fault >= 0) check(fault_led_out, e_fault);
    end
  end

  // Wide enough for paired values such as {err, rd}
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge mclk_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask

  task automatic sample16();
    c0 = 0;
    c1 = 0;
    f1 = 0;
    repeat (16)
    begin
      @(negedge mclk_in);
      c0 += (role_led_out === 2'b00);
      c1 += (role_led_out === 2'b01);
      f1 += (fault_led_out === 1'b1);
    end
  endtask

  task automatic press();
    @(posedge mclk_in) press_req <= 1;
    @(posedge mclk_in) press_req <= 0;
    repeat (5) @(posedge mclk_in);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #(25 * 6000);
    n_fail = n_fail + 1;
    stop_test();
  end

  initial
  begin
    repeat (2) @(posedge mclk_in);
    check(fault_led_out, 1);
    nrst_in <= 1;
    repeat (2) @(posedge mclk_in);
    live = 1;
    for (int i = 0; i < 4; i++)
    begin
      apb(0, 8'(4 * i + 4), 0);
      check(rd, thr[i]);
    end
    apb(0, 8'h40, 0);
    check({err, rd}, 33'h100000000);
    repeat (400)
    begin
      @(posedge mclk_in);
      r = $random(seed);
      if (r[3:0] == 0) alm_in <= alm_in ^ 4'(1 << r[5:4]);
      if (r[8:6] == 0) timing_locked_in <= ~timing_locked_in;
      if (r[11:9] == 0) supply_a_level_in <= r[31:20];
      if (r[14:12] == 0) supply_b_level_in <= r[27:16];
      if (r[19:15] == 0) active_role_in <= ~active_role_in;
      press_req <= (r[31:28] == 0);
    end
    // Thresholds swapped only while the live compare is paused
    live = 0;
    // A request left high would swallow the next press edge
    @(posedge mclk_in) press_req <= 0;
    for (int i = 0; i < 4; i++) apb(1, 8'(4 * i + 4), nt[i]);
    @(negedge mclk_in);
    thr = nt;
    // Last write lands late; resume once all four thresholds are in use
    @(posedge mclk_in);
    live = 1;
    for (int i = 0; i < 4; i++)
      for (int d = -1; d < 2; d++)
      begin
        @(posedge mclk_in);
        supply_a_level_in <= 12'(thr[i] + d);
        supply_b_level_in <= 12'(thr[3 - i] - d);
        repeat (2) @(posedge mclk_in);
      end
    apb(1, `CSIL_CTRL_OFS, 1);
    @(negedge mclk_in) hold = 1;
    @(posedge mclk_in) booting_in <= 1;
    repeat (12) @(posedge mclk_in);
    apb(1, `CSIL_CTRL_OFS, 0);
    @(negedge mclk_in) hold = 0;
    sample16();
    check(f1, 8);
    @(posedge mclk_in) booting_in <= 0;
    active_role_in <= 1;
    db_write_in <= 1;
    repeat (2) @(posedge mclk_in);
    sample16();
    check({c0, c1}, {32'd8, 32'd8});
    check(pull_ok, 0);
    @(posedge mclk_in) db_write_in <= 0;
    peer_db_write_in <= 1;
    repeat (2) @(posedge mclk_in);
    sample16();
    check(c0, 8);
    @(posedge mclk_in) peer_db_write_in <= 0;
    repeat (20) @(posedge mclk_in);
    check(pull_ok, 1);
    alm_in <= 0;
    apb(1, `CSIL_IRQ_STAT_OFS, 32'h3F);
    apb(1, `CSIL_IRQ_MASK_OFS, 0);
    @(posedge mclk_in) alm_in <= 4'h1;
    press();
    check({alarm_cutoff_led_out, audible_alarm_out}, 2'b10);
    apb(0, `CSIL_STATUS_OFS, 0);
    check({rd[4], irq_out}, 2'b10);
    apb(0, `CSIL_IRQ_STAT_OFS, 0);
    check(rd[1], 1);
    apb(1, `CSIL_IRQ_MASK_OFS, 32'h2);
    @(negedge mclk_in) check(irq_out, 1);
    @(posedge mclk_in) alm_in <= 4'h5;
    repeat (3) @(posedge mclk_in);
    check({alarm_cutoff_led_out, audible_alarm_out}, 2'b01);
    press();
    @(posedge mclk_in) alm_in <= 4'h4;
    repeat (3) @(posedge mclk_in);
    check(alarm_cutoff_led_out, 1);
    alm_in <= 0;
    repeat (3) @(posedge mclk_in);
    check({alarm_cutoff_led_out, audible_alarm_out}, 2'b00);
    apb(1, `CSIL_IRQ_STAT_OFS, 32'h3F);
    @(negedge mclk_in) check(irq_out, 0);
    stop_test();
  end
endmodule
